/* File: bench/sscl_far.sv */
// Far-side contacts: pushbuttons, selector, master run relay
`timescale 1ns/1ns
module sscl_far (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Operator and master
  input wire logic start_btn_i,
  input wire logic stop_btn_i,
  input wire logic master_run_i,
  input wire logic hand_i,
  // Contacts to starter
  output logic start_o,
  output logic stop_o,
  output logic sel_o
);
  logic start_d, stop_d, sel_d;
  // Stop wired ahead of start, so a held stop blocks the start button
  always_comb begin
    start_d = (start_btn_i && !stop_btn_i) || master_run_i;
    stop_d = !stop_btn_i;
    sel_d = hand_i;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {start_o, stop_o, sel_o} <= 3'h0;
    end else begin
      {start_o, stop_o, sel_o} <= {start_d, stop_d, sel_d};
    end
  end
endmodule

/* File: bench/sscl_sva.sv */
// Checker: port-level properties of the run-command block
`timescale 1ns/1ns
module sscl_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Run logic
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic selector_digital_input_i,
  input wire logic [3:0] relay_o,
  input wire logic running_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire setup = psel_i && !penable_i;
  wire sel = selector_digital_input_i;
  a_ready_next: assert property (setup |=> pready_o) else $error("no ready after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held");
  a_ready_cause: assert property (pready_o |-> $past(setup)) else $error("stray ready");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_refuse_bad: assert property (setup && (paddr_i > 8'h0C || pwrite_i && paddr_i == 8'h0C)
    |=> pslverr_o) else $error("bad access not refused");
  a_relay_off: assert property (!running_o |-> relay_o == 4'h0)
    else $error("relay on while stopped");
  a_run_cause: assert property ($rose(running_o) |-> $past(start_i)
    || $past(psel_i && pwrite_i) || $past(psel_i && pwrite_i, 2)) else $error("run uncaused");
  a_stop_cause: assert property ($fell(running_o) |-> !$past(start_i) || !$past(stop_i)
    || $past(psel_i) || $past(psel_i, 2) || $past(sel) != $past(sel, 2)
    || $past(sel, 2) != $past(sel, 3)) else $error("stop uncaused");
endmodule
bind sscl_top sscl_sva sscl_sva_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .start_i(start_i), .stop_i(stop_i),
  .selector_digital_input_i(selector_digital_input_i), .relay_o(relay_o),
  .running_o(running_o));

/* File: bench/tb_top.sv */
// Testbench: APB register access and run-command scenarios
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [6:0] firing_i = 7'h00, aout_o;
  logic [3:0] relay_o;
  logic pready_o, pslverr_o, start_i, stop_i, sel_i, running_o, er;
  logic sb = 1'b0, pb = 1'b0, mr = 1'b0, hd = 1'b0;
  int errors = 0, n_checks = 0, cyc = 0;
  sscl_top sscl_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .start_i(start_i),
    .stop_i(stop_i), .selector_digital_input_i(sel_i), .firing_i(firing_i),
    .relay_o(relay_o), .aout_o(aout_o), .running_o(running_o));
  sscl_far sscl_far_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_btn_i(sb),
    .stop_btn_i(pb), .master_run_i(mr), .hand_i(hd), .start_o(start_i), .stop_o(stop_i),
    .sel_o(sel_i));
  initial forever #25 clk_i = ~clk_i;
  // Ceiling far above the roughly 134 cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Only the bench ceiling ends a hang
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task done(input int t);
    $display("test %0d done", t);
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rdc(sscl_pkg::ADDR_CTRL, sscl_pkg::CTRL_RST);
    rdc(sscl_pkg::ADDR_SRC, sscl_pkg::SRC_RST);
    rdc(sscl_pkg::ADDR_AOUT, sscl_pkg::AOUT_RST);
    done(1);
    sb <= 1'b1; tick(3); chk(32'(relay_o), 32'hF);
    sb <= 1'b0; tick(3); chk(32'(relay_o), 32'h0);
    done(2);
    wr(sscl_pkg::ADDR_CTRL, 32'h0000_0508);
    sb <= 1'b1; tick(3); sb <= 1'b0; tick(3); chk(32'(relay_o), 32'h5);
    rdc(sscl_pkg::ADDR_STAT, 32'h3);
    pb <= 1'b1; tick(3); chk(32'(running_o), 32'h0);
    // Held master run after a stop must not restart without a new edge
    pb <= 1'b0; mr <= 1'b1; tick(3); pb <= 1'b1; tick(3); pb <= 1'b0; tick(3);
    rdc(sscl_pkg::ADDR_STAT, 32'h0);
    mr <= 1'b0; pb <= 1'b1; tick(3); mr <= 1'b1; tick(3); pb <= 1'b0; tick(3);
    rdc(sscl_pkg::ADDR_STAT, 32'h1);
    mr <= 1'b0; tick(3); chk(32'(running_o), 32'h0);
    done(3);
    wr(sscl_pkg::ADDR_CTRL, 32'h0000_0F18);
    wr(sscl_pkg::ADDR_SRC, 32'h2);
    hd <= 1'b1; tick(3);
    sb <= 1'b1; tick(3); sb <= 1'b0; chk(32'(running_o), 32'h0);
    wr(sscl_pkg::ADDR_CTRL, 32'h0000_0F19); tick(3); chk(32'(running_o), 32'h1);
    apb(1'b0, sscl_pkg::ADDR_STAT, 32'h0); chk(rd, 32'hF);
    wr(sscl_pkg::ADDR_CTRL, 32'h0000_0F1A); tick(3); chk(32'(running_o), 32'h0);
    wr(sscl_pkg::ADDR_CTRL, 32'h0000_0F19); tick(3); chk(32'(running_o), 32'h1);
    hd <= 1'b0; tick(3); chk(32'(running_o), 32'h0);
    sb <= 1'b1; tick(3); sb <= 1'b0; chk(32'(running_o), 32'h1);
    wr(sscl_pkg::ADDR_CTRL, 32'h0000_0F1C); tick(3); chk(32'(running_o), 32'h0);
    wr(sscl_pkg::ADDR_CTRL, 32'h0000_0F18); tick(3); chk(32'(running_o), 32'h0);
    done(4);
    wr(sscl_pkg::ADDR_AOUT, 32'h0000_3A0A);
    firing_i <= 7'h78; mr <= 1'b1; tick(3); chk(32'(aout_o), 32'h64);
    mr <= 1'b0; pb <= 1'b1; tick(3); chk(32'(aout_o), 32'h0);
    pb <= 1'b0; wr(sscl_pkg::ADDR_AOUT, 32'h0000_3A00); tick(3);
    chk(32'(aout_o), 32'h3A);
    done(5);
    apb(1'b0, 8'h10, 32'h0); chk({rd[30:0], er}, 32'h1);
    wr(sscl_pkg::ADDR_STAT, 32'hF); chk(32'(er), 32'h1);
    done(6);
    wrap_up();
  end
endmodule

/* File: common/sscl_pkg.sv */
// Package: constants and types for the start/stop control logic
package sscl_pkg;

  // ----------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRC = 8'h04;
  localparam logic [7:0] ADDR_AOUT = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;

  // ----------------------------------------------------------------
  // CTRL fields
  // ----------------------------------------------------------------
  localparam int CTRL_KEY_START = 0;
  localparam int CTRL_KEY_STOP = 1;
  localparam int CTRL_FAULT = 2;
  localparam int CTRL_STOP_EN = 3;
  localparam int CTRL_SEL_EN = 4;
  localparam int CTRL_RELAY_LO = 8;
  localparam int CTRL_RELAY_W = 4;

  // ----------------------------------------------------------------
  // SRC fields: local_source_setting bit 0, remote_source_setting bit 1
  // ----------------------------------------------------------------
  localparam int SRC_LOCAL = 0;
  localparam int SRC_REMOTE = 1;
  localparam logic SRC_TERMINAL = 1'b0;
  localparam logic SRC_KEYPAD = 1'b1;

  // ----------------------------------------------------------------
  // AOUT fields
  // ----------------------------------------------------------------
  localparam int AOUT_FUNC_LO = 0;
  localparam int AOUT_FUNC_W = 4;
  localparam int AOUT_FIRE_LO = 8;
  localparam int AOUT_FIRE_W = 7;
  localparam logic [3:0] AOUT_FUNC_FIRING = 4'hA;
  localparam logic [6:0] FIRE_MAX = 7'h64;

  // ----------------------------------------------------------------
  // STAT fields
  // ----------------------------------------------------------------
  localparam int STAT_RUN = 0;
  localparam int STAT_THREE = 1;
  localparam int STAT_REMOTE = 2;
  localparam int STAT_KEYPAD = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0F00;
  localparam logic [31:0] SRC_RST = 32'h0000_0000;
  localparam logic [31:0] AOUT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    SSCL_IDLE,
    SSCL_RUN2,
    SSCL_RUN3
  } sscl_state_e;

endpackage

/* File: hdl/sscl_edge.sv */
// Rising edge detector for the start input
`timescale 1ns/1ns
module sscl_edge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Level in, pulse out
  input wire logic lvl_i,
  output logic rise_o
);

  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = lvl_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise_o = lvl_i & ~prev_q;

endmodule

/* File: hdl/sscl_top.sv */
// Start/stop run-command logic with APB register access
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module sscl_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Digital inputs
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic selector_digital_input_i,
  // Firing level from phase control
  input wire logic [6:0] firing_i,
  // Outputs
  output logic [3:0] relay_o,
  output logic [6:0] aout_o,
  output logic running_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [1:0] src_q, src_d;
  logic [31:0] aout_cfg_q, aout_cfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  sscl_pkg::sscl_state_e state_q, state_d;
  logic keypad_prev_q, keypad_prev_d;
  logic [3:0] relay_q, relay_d;
  logic [6:0] aout_q, aout_d;
  logic running_q, running_d;

  logic start_rise;
  logic remote;
  logic keypad;
  logic cmd_start;
  logic src_change;
  logic setup;
  logic access;
  logic key_start;
  logic key_stop;
  logic stop_en;
  logic [3:0] aout_func;
  logic [6:0] fire_lim;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  sscl_edge u_edge (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .lvl_i(start_i),
    .rise_o(start_rise)
  );

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  assign remote = ctrl_q[sscl_pkg::CTRL_SEL_EN] & selector_digital_input_i;
  assign keypad = remote ? (src_q[sscl_pkg::SRC_REMOTE] == sscl_pkg::SRC_KEYPAD)
                         : (src_q[sscl_pkg::SRC_LOCAL] == sscl_pkg::SRC_KEYPAD);
  assign key_start = ctrl_q[sscl_pkg::CTRL_KEY_START];
  assign key_stop = ctrl_q[sscl_pkg::CTRL_KEY_STOP];
  assign stop_en = ctrl_q[sscl_pkg::CTRL_STOP_EN];
  assign src_change = keypad != keypad_prev_q;
  // Terminal start is ignored while keypad has control
  assign cmd_start = keypad ? key_start : start_rise;
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i & pready_q;

  // ----------------------------------------------------------------
  // Run state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    keypad_prev_d = keypad;
    if (ctrl_q[sscl_pkg::CTRL_FAULT] || src_change) begin
      state_d = sscl_pkg::SSCL_IDLE;
    end else begin
      unique case (state_q)
        sscl_pkg::SSCL_IDLE: begin
          if (keypad) begin
            if (key_start && !key_stop) begin
              state_d = sscl_pkg::SSCL_RUN3;
            end
          end else if (cmd_start) begin
            // Stop enable must be set and stop high at the edge, else fall back to 2-wire
            state_d = (stop_en && stop_i) ? sscl_pkg::SSCL_RUN3
                                          : sscl_pkg::SSCL_RUN2;
          end
        end
        sscl_pkg::SSCL_RUN2: begin
          if (!start_i) begin
            state_d = sscl_pkg::SSCL_IDLE;
          end
        end
        sscl_pkg::SSCL_RUN3: begin
          if (keypad ? key_stop : !stop_i) begin
            state_d = sscl_pkg::SSCL_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign aout_func = aout_cfg_q[sscl_pkg::AOUT_FUNC_LO +: sscl_pkg::AOUT_FUNC_W];
  assign fire_lim = (firing_i > sscl_pkg::FIRE_MAX) ? sscl_pkg::FIRE_MAX : firing_i;

  always_comb begin
    running_d = state_d != sscl_pkg::SSCL_IDLE;
    relay_d = running_d ? ctrl_q[sscl_pkg::CTRL_RELAY_LO +: sscl_pkg::CTRL_RELAY_W]
                        : 4'h0;
    if (aout_func == sscl_pkg::AOUT_FUNC_FIRING) begin
      aout_d = running_d ? fire_lim : 7'h00;
    end else begin
      aout_d = aout_cfg_q[sscl_pkg::AOUT_FIRE_LO +: sscl_pkg::AOUT_FIRE_W];
    end
  end

  // ----------------------------------------------------------------
  // APB slave, one wait-free access cycle
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    src_d = src_q;
    aout_cfg_d = aout_cfg_q;
    prdata_d = prdata_q;
    pready_d = setup;
    pslverr_d = 1'b0;
    // Keypad pushes are one-shot so a held bit cannot restart
    ctrl_d[sscl_pkg::CTRL_KEY_START] = 1'b0;
    ctrl_d[sscl_pkg::CTRL_KEY_STOP] = 1'b0;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (addr_hit(paddr_i, sscl_pkg::ADDR_CTRL)) begin
        prdata_d = ctrl_q & 32'hFFFF_FFFC;
      end else if (addr_hit(paddr_i, sscl_pkg::ADDR_SRC)) begin
        prdata_d = {30'h0, src_q};
      end else if (addr_hit(paddr_i, sscl_pkg::ADDR_AOUT)) begin
        prdata_d = aout_cfg_q;
      end else if (addr_hit(paddr_i, sscl_pkg::ADDR_STAT)) begin
        prdata_d = {28'h0, keypad, remote, state_q == sscl_pkg::SSCL_RUN3, running_q};
        pslverr_d = pwrite_i;
      end else begin
        pslverr_d = 1'b1;
      end
    end
    // Writes land only at the completing edge, when the master sees ready
    if (access && pwrite_i) begin
      if (addr_hit(paddr_i, sscl_pkg::ADDR_CTRL)) begin
        ctrl_d = pwdata_i & 32'h0000_0F1F;
      end else if (addr_hit(paddr_i, sscl_pkg::ADDR_SRC)) begin
        src_d = pwdata_i[1:0];
      end else if (addr_hit(paddr_i, sscl_pkg::ADDR_AOUT)) begin
        aout_cfg_d = pwdata_i & 32'h0000_7F0F;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= sscl_pkg::CTRL_RST;
      src_q <= sscl_pkg::SRC_RST[1:0];
      aout_cfg_q <= sscl_pkg::AOUT_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      state_q <= sscl_pkg::SSCL_IDLE;
      keypad_prev_q <= 1'b0;
      relay_q <= 4'h0;
      aout_q <= 7'h00;
      running_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      src_q <= src_d;
      aout_cfg_q <= aout_cfg_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      state_q <= state_d;
      keypad_prev_q <= keypad_prev_d;
      relay_q <= relay_d;
      aout_q <= aout_d;
      running_q <= running_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign relay_o = relay_q;
  assign aout_o = aout_q;
  assign running_o = running_q;

endmodule
